// ---- core/spi_frame_pkg.sv ----
// shared constants for the serial frame link: layout, length modes, timing
`default_nettype none
package spi_frame_pkg;
    localparam int ADDR_W = 16;
    localparam int BLOCK_W = 5;
    localparam int HDR_BITS = 24;
    // header bit positions once all 24 bits are shifted in
    localparam int ADDR_POS = 8;
    localparam int BLOCK_POS = 3;
    localparam int RW_POS = 2;
    localparam int LEN_POS = 0;
    // count of header bits already taken when the read/write bit arrives
    localparam logic [4:0] RW_BIT_IDX = 5'h15;
    localparam logic [4:0] HDR_LAST_IDX = 5'h17;
    localparam logic [1:0] LEN_VAR = 2'h0;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_FOUR = 2'h3;
    localparam logic RW_WRITE = 1'b1;
    localparam logic RW_READ = 1'b0;
    localparam logic [4:0] BLOCK_COMMON = 5'h00;
    localparam int CLOCK_NS = 5;
    localparam int SCLK_HALF_NS = 20;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS;

    function automatic logic [7:0] fixed_bytes(input logic [1:0] len);
        case (len)
            LEN_ONE: fixed_bytes = 8'h01;
            LEN_TWO: fixed_bytes = 8'h02;
            LEN_FOUR: fixed_bytes = 8'h04;
            default: fixed_bytes = 8'h00;
        endcase
    endfunction
endpackage
`default_nettype wire

// ---- core/spi_link_if.sv ----
// serial link between host and frame device, one modport per end
`default_nettype none
interface spi_link_if;
    logic sclk;
    logic chip_select_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;
    // undriven data line reads high, as with a pull-up
    assign miso_line = miso_oe ? miso : 1'b1;
    modport device(input sclk, input chip_select_n, input mosi, output miso, output miso_oe);
    modport host(output sclk, output chip_select_n, output mosi, input miso_line);
endinterface
`default_nettype wire

// ---- core/spi_frame_device.sv ----
// frame device end: header parse, data phase, crossing to the user clock
// Notes on behaviour
// RULE1: variable frames: data runs while select low
// RULE2: host sends length 00 for variable frames
// RULE3: read/write bit 1 means write, store MOSI
// RULE4: host lowers select before first frame bit
// RULE5: MOSI changes on falling, sampled on rising
// RULE6: select rising edge ends the frame
// RULE7: keep accepting write bytes while select low
// RULE8: write bytes go to successive offsets
// RULE9: read/write bit 0 means read
// RULE10: device drives MISO bits during read data
// RULE11: keep returning successive offsets while clocked
// RULE12: five-bit block field picks target region
// RULE13: fixed mode keeps select tied low
// RULE14: fixed length field gives 1, 2, 4 bytes
// RULE15: fixed frames share the variable frame layout
// RULE16: host uses only 1, 2 or 4 bytes
// RULE17: bytes travel most significant bit first
// RULE18: after fixed length, next bit starts address
// RULE19: select rising aborts partial frame
`default_nettype none
module spi_frame_device (
    input wire logic clock,
    input wire logic rst_b,
    spi_link_if.device link,
    output logic wr_en,
    output logic [spi_frame_pkg::BLOCK_W-1:0] wr_block,
    output logic [spi_frame_pkg::ADDR_W-1:0] wr_offset,
    output logic [7:0] wr_data,
    output logic rd_req,
    output logic [spi_frame_pkg::BLOCK_W-1:0] rd_block,
    output logic [spi_frame_pkg::ADDR_W-1:0] rd_offset,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    typedef struct packed {
        logic [4:0] hdr_cnt;
        logic in_data;
        logic [23:0] hdr;
        logic [2:0] bit_cnt;
        logic [7:0] byte_cnt;
        logic [7:0] rx;
        logic [15:0] addr;
        logic load;
    } frame_t;

    typedef struct packed {
        logic wr_tog;
        logic [28:0] wr_word;
        logic rd_tog;
        logic [20:0] rd_word;
    } event_t;

    typedef struct packed {
        logic [7:0] mo;
        logic oe;
    } out_t;

    typedef struct packed {
        logic [2:0] wr_s;
        logic [2:0] rd_s;
        logic wr_en;
        logic [4:0] wr_block;
        logic [15:0] wr_offset;
        logic [7:0] wr_data;
        logic rd_req;
        logic [4:0] rd_block;
        logic [15:0] rd_offset;
        logic [7:0] rd_hold;
    } user_t;

    frame_t f_q, f_d;
    event_t e_q, e_d;
    out_t o_q, o_d;
    user_t u_q, u_d;
    logic frame_rst_b;
    logic is_read;
    logic [1:0] len;
    logic [4:0] block;
    logic [7:0] rx_next;
    logic last_fixed;

    // the frame's own select ends it; no link edge is needed after it rises
    assign frame_rst_b = rst_b & ~link.chip_select_n; // see RULE6 see RULE19
    assign is_read = f_q.hdr[spi_frame_pkg::RW_POS] == spi_frame_pkg::RW_READ; // see RULE9
    assign len = f_q.hdr[spi_frame_pkg::LEN_POS +: 2];
    assign block = f_q.hdr[spi_frame_pkg::BLOCK_POS +: spi_frame_pkg::BLOCK_W]; // see RULE12
    assign rx_next = {f_q.rx[6:0], link.mosi}; // see RULE17
    assign last_fixed = len != spi_frame_pkg::LEN_VAR
        && f_q.byte_cnt + 8'h01 == spi_frame_pkg::fixed_bytes(len); // see RULE14

    // frame parser on the link clock, sampling MOSI on the rising edge
    always_comb begin
        f_d = f_q;
        f_d.load = 1'b0;
        if (!f_q.in_data) begin
            f_d.hdr = {f_q.hdr[22:0], link.mosi}; // see RULE5 see RULE15
            f_d.hdr_cnt = f_q.hdr_cnt + 5'h01;
            if (f_q.hdr_cnt == spi_frame_pkg::HDR_LAST_IDX) begin
                f_d.in_data = 1'b1;
                f_d.hdr_cnt = 5'h00;
                f_d.bit_cnt = 3'h0;
                f_d.byte_cnt = 8'h00;
                f_d.addr = f_d.hdr[spi_frame_pkg::ADDR_POS +: spi_frame_pkg::ADDR_W];
                f_d.load = f_d.hdr[spi_frame_pkg::RW_POS] == spi_frame_pkg::RW_READ;
            end
        end else begin
            f_d.rx = rx_next;
            f_d.bit_cnt = f_q.bit_cnt + 3'h1;
            if (f_q.bit_cnt == 3'h7) begin
                // variable frames run on until select rises
                f_d.byte_cnt = f_q.byte_cnt + 8'h01; // see RULE1 see RULE7 see RULE11
                f_d.addr = f_q.addr + 16'h0001; // see RULE8
                f_d.load = is_read;
                if (last_fixed) begin
                    f_d = '0; // see RULE18
                end
            end
        end
    end

    always_ff @(posedge link.sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    // events keep their toggles across frames, so only the main reset clears them
    always_comb begin
        e_d = e_q;
        if (f_q.in_data && !is_read && f_q.bit_cnt == 3'h7) begin
            e_d.wr_tog = ~e_q.wr_tog; // see RULE3
            e_d.wr_word = {block, f_q.addr, rx_next};
        end
        // fetch early: the first byte is due two and a half link bits later
        if (!f_q.in_data && f_q.hdr_cnt == spi_frame_pkg::RW_BIT_IDX
            && link.mosi == spi_frame_pkg::RW_READ) begin
            e_d.rd_tog = ~e_q.rd_tog; // see RULE9
            // block bits still sit below the offset here, so swap to block-then-offset
            e_d.rd_word = {f_q.hdr[4:0], f_q.hdr[20:5]};
        end
        if (f_q.in_data && is_read && f_q.bit_cnt == 3'h0 && !last_fixed) begin
            e_d.rd_tog = ~e_q.rd_tog; // see RULE11
            e_d.rd_word = {block, f_q.addr + 16'h0001};
        end
    end

    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            e_q <= '0;
        end else begin
            e_q <= e_d;
        end
    end

    // MISO moves on the falling edge so the host can sample on the rising one
    always_comb begin
        o_d.oe = f_q.in_data & is_read; // see RULE10
        if (f_q.load) begin
            o_d.mo = u_q.rd_hold;
        end else begin
            o_d.mo = {o_q.mo[6:0], 1'b0}; // see RULE17
        end
    end

    always_ff @(negedge link.sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            o_q <= '0;
        end else begin
            o_q <= o_d;
        end
    end

    assign link.miso = o_q.mo[7];
    assign link.miso_oe = o_q.oe;

    // user side: toggles pass two flops, words are stable by then
    always_comb begin
        u_d = u_q;
        u_d.wr_s = {u_q.wr_s[1:0], e_q.wr_tog};
        u_d.rd_s = {u_q.rd_s[1:0], e_q.rd_tog};
        u_d.wr_en = u_q.wr_s[2] ^ u_q.wr_s[1];
        u_d.rd_req = u_q.rd_s[2] ^ u_q.rd_s[1];
        if (u_q.wr_s[2] ^ u_q.wr_s[1]) begin
            {u_d.wr_block, u_d.wr_offset, u_d.wr_data} = e_q.wr_word; // see RULE8
        end
        if (u_q.rd_s[2] ^ u_q.rd_s[1]) begin
            {u_d.rd_block, u_d.rd_offset} = e_q.rd_word;
        end
        if (rd_valid) begin
            u_d.rd_hold = rd_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            u_q <= '0;
        end else begin
            u_q <= u_d;
        end
    end

    assign wr_en = u_q.wr_en;
    assign wr_block = u_q.wr_block;
    assign wr_offset = u_q.wr_offset;
    assign wr_data = u_q.wr_data;
    assign rd_req = u_q.rd_req;
    assign rd_block = u_q.rd_block;
    assign rd_offset = u_q.rd_offset;
endmodule
`default_nettype wire

// ---- core/spi_frame_host.sv ----
// host end: builds frames, divides its clock down to the link clock
`default_nettype none
module spi_frame_host #(
    parameter int HALF = spi_frame_pkg::SCLK_HALF_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    spi_link_if.host link,
    input wire logic fixed_select,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [spi_frame_pkg::BLOCK_W-1:0] cmd_block,
    input wire logic [spi_frame_pkg::ADDR_W-1:0] cmd_offset,
    input wire logic [1:0] cmd_len_mode,
    input wire logic [7:0] cmd_count,
    input wire logic [7:0] tx_byte,
    output logic tx_take,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic done
);
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} hstate_t;

    typedef struct packed {
        hstate_t st;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic [23:0] sh;
        logic [4:0] hdr_cnt;
        logic in_data;
        logic [2:0] bit_cnt;
        logic [7:0] left;
        logic write;
        logic [1:0] m_s;
        logic ready;
        logic take;
        logic [7:0] rx;
        logic rx_valid;
        logic done;
    } host_t;

    host_t h_q, h_d;
    logic half_done;
    assign half_done = h_q.div == 8'(HALF - 1);

    always_comb begin
        h_d = h_q;
        h_d.m_s = {h_q.m_s[0], link.miso_line};
        h_d.take = 1'b0;
        h_d.rx_valid = 1'b0;
        h_d.done = 1'b0;
        h_d.div = half_done ? 8'h00 : h_q.div + 8'h01;
        case (h_q.st)
            H_IDLE: begin
                h_d.div = 8'h00;
                h_d.cs_n = ~fixed_select; // see RULE13
                h_d.ready = 1'b1;
                if (cmd_valid && h_q.ready) begin
                    h_d.ready = 1'b0;
                    h_d.st = H_LOW;
                    h_d.cs_n = 1'b0; // see RULE4
                    h_d.sh = {cmd_offset, cmd_block, cmd_write, cmd_len_mode}; // see RULE2 see RULE3
                    h_d.hdr_cnt = 5'h00;
                    h_d.in_data = 1'b0;
                    h_d.write = cmd_write;
                    // a fixed frame is 1, 2 or 4 bytes; length 00 gives no data bytes
                    h_d.left = fixed_select ? spi_frame_pkg::fixed_bytes(cmd_len_mode) : cmd_count; // see RULE16
                end
            end
            H_LOW: begin
                if (half_done) begin
                    h_d.sclk = 1'b1;
                    h_d.st = H_HIGH;
                    if (h_q.in_data && !h_q.write) begin
                        h_d.rx = {h_q.rx[6:0], h_q.m_s[1]}; // see RULE10 see RULE17
                        h_d.rx_valid = h_q.bit_cnt == 3'h7;
                    end
                end
            end
            H_HIGH: begin
                if (half_done) begin
                    h_d.sclk = 1'b0; // see RULE5
                    h_d.st = H_LOW;
                    h_d.sh = {h_q.sh[22:0], 1'b0};
                    h_d.hdr_cnt = h_q.hdr_cnt + 5'h01;
                    h_d.bit_cnt = h_q.bit_cnt + 3'h1;
                    if (!h_q.in_data && h_q.hdr_cnt == spi_frame_pkg::HDR_LAST_IDX
                        || h_q.in_data && h_q.bit_cnt == 3'h7) begin
                        h_d.in_data = 1'b1;
                        h_d.bit_cnt = 3'h0;
                        h_d.left = h_q.in_data ? h_q.left - 8'h01 : h_q.left;
                        if (h_d.left == 8'h00) begin
                            h_d.st = H_GAP;
                        end else if (h_q.write) begin
                            h_d.sh = {tx_byte, 16'h0000}; // see RULE17
                            h_d.take = 1'b1;
                        end else begin
                            h_d.sh = '0; // see RULE9
                        end
                    end
                end
            end
            H_GAP: begin
                h_d.cs_n = ~fixed_select; // see RULE6
                if (half_done) begin
                    h_d.st = H_IDLE;
                    h_d.done = 1'b1;
                end
            end
            default: h_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            h_q <= '{st: H_IDLE, cs_n: 1'b1, default: '0};
        end else begin
            h_q <= h_d;
        end
    end

    assign link.sclk = h_q.sclk;
    assign link.chip_select_n = h_q.cs_n;
    assign link.mosi = h_q.sh[23];
    assign cmd_ready = h_q.ready;
    assign tx_take = h_q.take;
    assign rx_byte = h_q.rx;
    assign rx_valid = h_q.rx_valid;
    assign done = h_q.done;
endmodule
`default_nettype wire

// ---- sim/spi_frame_asserts.sv ----
// concurrent checks on the serial link between host and device ends
`default_nettype none
module spi_frame_asserts (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] nbit;
        logic [23:0] hdr;
    } mon_t;
    mon_t mon_q, mon_d;
    logic [7:0] nbit;
    logic [7:0] frame_bits;
    logic rd_data_bit;
    logic wr_data_bit;
    assign nbit = mon_q.nbit;
    assign frame_bits = 8'h18 + (mon_q.hdr[1:0] == 2'h3 ? 8'h20 : {3'h0, mon_q.hdr[1:0], 3'h0});
    assign rd_data_bit = nbit >= 8'h18 && mon_q.hdr[spi_frame_pkg::RW_POS] == spi_frame_pkg::RW_READ;
    assign wr_data_bit = nbit >= 8'h18 && mon_q.hdr[spi_frame_pkg::RW_POS] == spi_frame_pkg::RW_WRITE;
    // fixed frames wrap the count; variable ones run until select rises
    always_comb begin
        mon_d = mon_q;
        if (mon_q.nbit < 8'h18) begin
            mon_d.hdr = {mon_q.hdr[22:0], mosi};
        end
        mon_d.nbit = mon_q.nbit + 8'h01;
        if (mon_q.nbit >= 8'h18 && mon_q.hdr[1:0] != spi_frame_pkg::LEN_VAR && mon_d.nbit == frame_bits) begin
            mon_d.nbit = 8'h00;
        end
    end
    always_ff @(posedge sclk or posedge chip_select_n or negedge rst_b) begin
        if (!rst_b || chip_select_n) begin
            mon_q <= '0;
        end else begin
            mon_q <= mon_d;
        end
    end
    property p_hdr_quiet;
        @(posedge sclk) disable iff (!rst_b || chip_select_n) nbit >= 8'h02 && nbit < 8'h18 |-> !miso_oe;
    endproperty
    a_hdr_quiet: assert property (p_hdr_quiet) else $error("miso driven during header");
    property p_read_drive;
        @(posedge sclk) disable iff (!rst_b || chip_select_n) rd_data_bit |-> miso_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("miso not driven in read data");
    property p_write_quiet;
        @(posedge sclk) disable iff (!rst_b || chip_select_n) wr_data_bit |-> !miso_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("miso driven in write data");
    property p_sclk_idle;
        @(posedge clock) disable iff (!rst_b) chip_select_n |-> !sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("link clock runs while deselected");
    property p_cs_lead;
        @(posedge clock) disable iff (!rst_b) $fell(chip_select_n) |-> !sclk [*2];
    endproperty
    a_cs_lead: assert property (p_cs_lead) else $error("select not ahead of first clock");
    property p_mosi_hold;
        @(posedge clock) disable iff (!rst_b) sclk |-> $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while clock high");
    property p_miso_hold;
        @(posedge clock) disable iff (!rst_b) sclk && miso_oe |-> $stable(miso);
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved while clock high");
    property p_release;
        @(posedge clock) disable iff (!rst_b) chip_select_n |-> !miso_oe;
    endproperty
    a_release: assert property (p_release) else $error("miso driven while deselected");
    property p_cs_end;
        @(posedge clock) disable iff (!rst_b) $rose(chip_select_n) |-> $past(nbit) >= 8'h20 && $past(nbit) % 8 == 0;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("select rose mid byte");
    c_multi: cover property (@(posedge clock) disable iff (!rst_b) $rose(chip_select_n) && $past(nbit) >= 8'h40);
    c_read: cover property (@(posedge sclk) disable iff (!rst_b || chip_select_n) rd_data_bit);
    c_fixed: cover property (@(posedge sclk) disable iff (!rst_b) mon_q.hdr[1:0] != 2'h0 && nbit >= 8'h18);
endmodule
`default_nettype wire

// ---- sim/spi_frame_slave_vdm_fdm_tb.sv ----
// self-checking bench: host end driving device end across the link
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module spi_frame_slave_vdm_fdm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic fx;
        logic wr;
        logic [4:0] blk;
        logic [15:0] off;
        logic [1:0] len;
        logic [7:0] n;
        logic [7:0] base;
    } row_t;
    logic clock, rst_b, fixed_select, cmd_valid, cmd_ready, cmd_write, tx_take, rx_valid, done;
    logic wr_en, rd_req, rd_valid;
    logic [4:0] cmd_block, wr_block, rd_block;
    logic [15:0] cmd_offset, wr_offset, rd_offset;
    logic [1:0] cmd_len_mode;
    logic [7:0] cmd_count, tx_byte, rx_byte, wr_data, rd_data, tx_cnt, wr_k, rd_k;
    logic [23:0] wire_hdr;
    int wire_n, fail_count, cmp_count, i;
    row_t cur;
    row_t rows [11] = '{'{1'b0, 1'b1, 5'h00, 16'h0018, 2'h0, 8'h01, 8'haa}, '{1'b0, 1'b1, 5'h06, 16'h0040, 2'h0, 8'h05, 8'h11},
        '{1'b0, 1'b1, 5'h01, 16'hfffe, 2'h0, 8'h02, 8'h5a}, '{1'b0, 1'b0, 5'h1d, 16'h0003, 2'h0, 8'h01, 8'h00},
        '{1'b0, 1'b0, 5'h0f, 16'h0100, 2'h0, 8'h05, 8'h00}, '{1'b1, 1'b1, 5'h02, 16'h1234, 2'h1, 8'h00, 8'h3c},
        '{1'b1, 1'b1, 5'h0a, 16'h0200, 2'h2, 8'h00, 8'h70}, '{1'b1, 1'b1, 5'h12, 16'h0300, 2'h3, 8'h00, 8'h81},
        '{1'b1, 1'b0, 5'h07, 16'h0010, 2'h1, 8'h00, 8'h00}, '{1'b1, 1'b0, 5'h0b, 16'h0020, 2'h2, 8'h00, 8'h00},
        '{1'b1, 1'b0, 5'h1f, 16'h0030, 2'h3, 8'h00, 8'h00}};
    spi_link_if link();
    spi_frame_host i_spi_frame_host (.clock(clock), .rst_b(rst_b), .link(link), .fixed_select(fixed_select),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_block(cmd_block),
        .cmd_offset(cmd_offset), .cmd_len_mode(cmd_len_mode), .cmd_count(cmd_count), .tx_byte(tx_byte),
        .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid), .done(done));
    spi_frame_device i_spi_frame_device (.clock(clock), .rst_b(rst_b), .link(link), .wr_en(wr_en),
        .wr_block(wr_block), .wr_offset(wr_offset), .wr_data(wr_data), .rd_req(rd_req), .rd_block(rd_block),
        .rd_offset(rd_offset), .rd_valid(rd_valid), .rd_data(rd_data));
    spi_frame_asserts i_spi_frame_asserts (.clock(clock), .rst_b(rst_b), .sclk(link.sclk),
        .chip_select_n(link.chip_select_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
    function automatic logic [7:0] mem(input logic [4:0] b, input logic [15:0] o);
        return o[7:0] ^ {b, 3'h5};
    endfunction
    always #2.5 clock = ~clock;
    // user-side memory answers one clock after each fetch, well inside the allowed window
    always @(posedge clock) begin
        rd_valid <= rd_req;
        rd_data <= mem(rd_block, rd_offset);
        if (tx_take) tx_cnt <= tx_cnt + 8'h01;
        tx_byte <= cur.base + 8'h11 * (tx_cnt + {7'h0, tx_take});
        if (wr_en) begin
            `CHK("wr_block", cur.blk, wr_block)
            `CHK("wr_offset", cur.off + {8'h0, wr_k}, wr_offset)
            `CHK("wr_data", cur.base + 8'h11 * wr_k, wr_data)
            wr_k <= wr_k + 8'h01;
        end
        if (rx_valid) begin
            `CHK("rx_byte", mem(cur.blk, cur.off + {8'h0, rd_k}), rx_byte)
            rd_k <= rd_k + 8'h01;
        end
        if (rd_req) `CHK("rd_block", cur.blk, rd_block)
    end
    always @(posedge link.sclk) begin
        if (wire_n < 24) wire_hdr <= {wire_hdr[22:0], link.mosi};
        wire_n <= wire_n + 1;
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic run(input row_t r);
        int k;
        logic [7:0] n;
        n = r.fx ? (r.len == 2'h3 ? 8'h04 : {6'h0, r.len}) : r.n;
        for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) @(posedge clock);
        if (k >= 50) begin
            fail_count++;
            results();
        end
        cur = r;
        wr_k = 8'h00;
        rd_k = 8'h00;
        tx_cnt = 8'h00;
        wire_n = 0;
        fixed_select <= r.fx;
        repeat (2) @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= r.wr;
        cmd_block <= r.blk;
        cmd_offset <= r.off;
        cmd_len_mode <= r.len;
        cmd_count <= n;
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clock);
        if (k >= 3000) begin
            fail_count++;
            results();
        end
        repeat (8) @(posedge clock);
        `CHK("bytes", n, r.wr ? wr_k : rd_k)
        `CHK("header", {r.off, r.blk, r.wr, r.len}, wire_hdr)
    endtask
    initial begin
        clock = 0;
        // nba so the async resets already wait and see a falling edge at time zero
        rst_b <= 1'b0;
        {fixed_select, cmd_valid, cmd_write, cmd_block, cmd_offset, cmd_len_mode, cmd_count} = '0;
        {tx_byte, rd_valid, rd_data, tx_cnt, wr_k, rd_k} = '0;
        cur = rows[0];
        repeat (5) @(posedge clock);
        `CHK("cs_reset", 1'b1, link.chip_select_n)
        `CHK("oe_reset", 1'b0, link.miso_oe)
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("ready", 1'b1, cmd_ready)
        for (i = 0; i < 11; i++) run(rows[i]);
        // reset in mid-frame, then a plain frame must still parse
        fixed_select <= 1'b0;
        cur = rows[4];
        cmd_write <= rows[4].wr;
        cmd_block <= rows[4].blk;
        cmd_offset <= rows[4].off;
        cmd_len_mode <= rows[4].len;
        cmd_count <= rows[4].n;
        cmd_valid <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        repeat (150) @(posedge clock);
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        `CHK("cs_abort", 1'b1, link.chip_select_n)
        `CHK("oe_abort", 1'b0, link.miso_oe)
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("ready_again", 1'b1, cmd_ready)
        run(rows[4]);
        run(rows[1]);
        results();
    end
endmodule
`undef CHK
`default_nettype wire
